/* rtc_alarm_consts.vh */
`ifndef RTC_ALARM_CONSTS_VH
`define RTC_ALARM_CONSTS_VH

// serial slave select for the clock/control space
`define CCR_DEV_ADDR 7'h6F

// clock/control byte addresses
`define ADR_ALARM0_BASE 16'h0000
`define ADR_ALARM1_BASE 16'h0008
`define ADR_ALARM_LAST 16'h000F
`define ADR_PROTECT 16'h0010
`define ADR_ATRIM 16'h0012
`define ADR_DTRIM 16'h0013
`define ADR_POWER 16'h0014
`define ADR_TIME_SEC 16'h0030
`define ADR_TIME_MIN 16'h0031
`define ADR_TIME_HOUR 16'h0032
`define ADR_TIME_DATE 16'h0033
`define ADR_TIME_MONTH 16'h0034
`define ADR_TIME_YEAR 16'h0035
`define ADR_TIME_DOW 16'h0036
`define ADR_STATUS 16'h003F

// alarm byte index inside a bank
`define AL_SEC 3'h0
`define AL_MIN 3'h1
`define AL_HOUR 3'h2
`define AL_DATE 3'h3
`define AL_MONTH 3'h4
`define AL_YEAR 3'h5
`define AL_DOW 3'h6
`define AL_ENABLE_BIT 7

// field positions
`define PROT_SEL_MSB 7
`define PROT_SEL_LSB 5
`define PROT_KEEP_LSB 3
`define ATRIM_MSB 5
`define DTRIM_SIGN 2
`define DTRIM_10PPM 1
`define DTRIM_20PPM 0
`define POWER_SERIAL_OFF 7
`define POWER_SWITCHOVER 6
`define POWER_THR_MSB 2
`define ST_BATTERY 7
`define ST_FLAG_B 6
`define ST_FLAG_A 5

// reset values
`define PROTECT_RESET 5'h03
`define ATRIM_RESET 6'h00
`define DTRIM_RESET 3'h0
`define THR_RESET 3'h0
`define ALARM_RESET 8'h00

// supply monitor codes
`define THR_LEVEL_LAST 3'h4

// digital trim averaging
`define TRIM_STEP_PPM 7'h0A
`define TRIM_DOUBLE_PPM 7'h14
`define OSC_COUNTS_PER_SEC 16'h8000
`define PPM_SCALE 21'h0F4240

`endif

/* alarm_bank_match.v */
`timescale 1ns/1ps
// one alarm bank compared against the running time; year is never a field
module alarm_bank_match #(
  parameter FIELDS = 6
) (
  input wire [8*FIELDS-1:0] alarm_bytes,
  input wire [8*FIELDS-1:0] time_bytes,
  output reg match
);
  integer i;
  reg any_enabled;
  reg all_equal;

  always @* begin
    any_enabled = 1'b0;
    all_equal = 1'b1;
    for (i = 0; i < FIELDS; i = i + 1) begin
      if (alarm_bytes[8*i+7]) begin
        any_enabled = 1'b1;
        if (alarm_bytes[8*i +: 7] != time_bytes[8*i +: 7]) begin
          all_equal = 1'b0;
        end
      end
    end
    // an all-disabled bank would otherwise match every second
    match = any_enabled & all_equal;
  end
endmodule // alarm_bank_match

/* rtc_alarm_ctrl.v */
// Contract
// - each alarm byte mirrors its time byte; MSB one enables that field.
// - no year field takes part in the alarm comparison.
// - alarm fires when all enabled fields equal the running time.
// - any non-empty subset of fields may be enabled for a match.
// - protect, trim and power settings survive loss of power.
// - array writes inside the protected region are silently dropped.
// - protect selector codes 1 to 7 map to six protected address ranges; 3 and 7 both lock all.
// - six-bit analog code sets both load capacitors; zero gives 12.5pF.
// - digital trim changes oscillator counts per second, averaged.
// - digital trim top bit is sign: zero positive, one negative.
// - trim bit one adds 10ppm, bit zero adds 20ppm.
// - serial-off bit one disables the serial bus on battery.
// - switchover bit zero standard, one legacy; default per variant.
// - threshold selector picks supply monitor level, 4.64V down to 2.63V.
// - threshold selector writes are never write protected.
// - supply below selected level puts device in reset, bus silent.
// - on battery, reset stays low until main supply returns.
// - an alarm match sets that bank's status flag.
// - both alarm flags clear at eighth clock fall of status read.
`timescale 1ns/1ps
`include "rtc_alarm_consts.vh"
module rtc_alarm_ctrl #(
  parameter SWITCHOVER_DEFAULT = 1'b1,
  parameter ARRAY_AW = 9
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire [7:0] time_sec,
  input wire [7:0] time_min,
  input wire [7:0] time_hour,
  input wire [7:0] time_date,
  input wire [7:0] time_month,
  input wire [7:0] time_year,
  input wire [7:0] time_dow,
  input wire sec_tick,
  input wire battery_mode,
  input wire [4:0] supply_above,
  input wire array_wr_req,
  input wire [ARRAY_AW-1:0] array_wr_addr,
  output reg array_wr_grant,
  output reg alarm_flag_a,
  output reg alarm_flag_b,
  output reg [2:0] protect_sel,
  output reg [5:0] analog_trim_code,
  output reg [5:0] load_cap_code,
  output reg [2:0] digital_trim,
  output reg [15:0] second_length,
  output reg serial_off_in_backup,
  output reg switchover_mode_sel,
  output reg [2:0] supply_monitor_level,
  output reg reset_out_n,
  output reg serial_active
);
  localparam ST_IDLE = 3'h0;
  localparam ST_DEV = 3'h1;
  localparam ST_ADDR_HI = 3'h2;
  localparam ST_ADDR_LO = 3'h3;
  localparam ST_WRITE = 3'h4;
  localparam ST_READ = 3'h5;

  // pin synchronisers
  reg scl_s1, scl_s2, scl_d;
  reg sda_s1, sda_s2, sda_d;
  reg bat_s1, bat_s2;
  reg [4:0] sup_s1, sup_s2;

  reg [7:0] alarm_mem [0:15];
  reg [1:0] protect_keep;
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] tx;
  reg [15:0] addr;
  reg reset_hold;
  reg [20:0] trim_acc;
  reg status_clear;
  integer k;
  // protect byte reset packs {selector, keep bits}
  wire [4:0] protect_reset = `PROTECT_RESET;

  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  // reserved codes fall back to the top level rather than a new one
  reg below_level;
  always @* begin
    case (supply_monitor_level)
      3'h0: below_level = ~sup_s2[0];
      3'h1: below_level = ~sup_s2[1];
      3'h2: below_level = ~sup_s2[2];
      3'h3: below_level = ~sup_s2[3];
      3'h4: below_level = ~sup_s2[4];
      default: below_level = ~sup_s2[0];
    endcase
  end

  wire lvr_active = below_level | reset_hold;
  wire bus_on = ~lvr_active & ~(bat_s2 & serial_off_in_backup);

  // protected range check for the array
  reg in_protected;
  always @* begin
    case (protect_sel)
      3'h1: in_protected = (array_wr_addr >= 9'h180);
      3'h2: in_protected = (array_wr_addr >= 9'h100);
      3'h3: in_protected = 1'b1;
      3'h4: in_protected = (array_wr_addr <= 9'h03F);
      3'h5: in_protected = (array_wr_addr <= 9'h07F);
      3'h6: in_protected = (array_wr_addr <= 9'h0FF);
      3'h7: in_protected = 1'b1;
      default: in_protected = 1'b0;
    endcase
  end

  // alarm comparison, year byte left out of both banks
  wire [47:0] time_bytes = {time_dow, time_month, time_date, time_hour, time_min, time_sec};
  wire [47:0] bank_a = {alarm_mem[6], alarm_mem[4], alarm_mem[3],
                        alarm_mem[2], alarm_mem[1], alarm_mem[0]};
  wire [47:0] bank_b = {alarm_mem[14], alarm_mem[12], alarm_mem[11],
                        alarm_mem[10], alarm_mem[9], alarm_mem[8]};
  wire match_a;
  wire match_b;

  alarm_bank_match #(
    .FIELDS(6)
  ) u_bank_a (
    .alarm_bytes(bank_a),
    .time_bytes(time_bytes),
    .match(match_a)
  );

  alarm_bank_match #(
    .FIELDS(6)
  ) u_bank_b (
    .alarm_bytes(bank_b),
    .time_bytes(time_bytes),
    .match(match_b)
  );

  // read data mux
  reg [7:0] rd_data;
  always @* begin
    rd_data = 8'h00;
    if (addr <= `ADR_ALARM_LAST) begin
      if (addr[2:0] != `AL_YEAR) begin
        rd_data = alarm_mem[addr[3:0]];
      end
    end else begin
      case (addr)
        `ADR_PROTECT: rd_data = {protect_sel, protect_keep, 3'h0};
        `ADR_ATRIM: rd_data = {2'h0, analog_trim_code};
        `ADR_DTRIM: rd_data = {5'h00, digital_trim};
        `ADR_POWER: rd_data = {serial_off_in_backup, switchover_mode_sel, 3'h0,
                               supply_monitor_level};
        `ADR_TIME_SEC: rd_data = time_sec;
        `ADR_TIME_MIN: rd_data = time_min;
        `ADR_TIME_HOUR: rd_data = time_hour;
        `ADR_TIME_DATE: rd_data = time_date;
        `ADR_TIME_MONTH: rd_data = time_month;
        `ADR_TIME_YEAR: rd_data = time_year;
        `ADR_TIME_DOW: rd_data = time_dow;
        `ADR_STATUS: rd_data = {bat_s2, alarm_flag_b, alarm_flag_a, 5'h00};
        default: rd_data = 8'h00;
      endcase
    end
  end

  // digital trim magnitude in ppm
  wire [6:0] trim_ppm = (digital_trim[`DTRIM_10PPM] ? `TRIM_STEP_PPM : 7'h00) +
                        (digital_trim[`DTRIM_20PPM] ? `TRIM_DOUBLE_PPM : 7'h00);
  // magnitude never exceeds 30, so six bits carry it without loss
  wire [20:0] trim_sum = trim_acc + {trim_ppm[5:0], 15'h0000};

  always @(posedge clk) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      bat_s1 <= 1'b0;
      bat_s2 <= 1'b0;
      sup_s1 <= 5'h1F;
      sup_s2 <= 5'h1F;
    end else if (ce) begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      bat_s1 <= battery_mode;
      bat_s2 <= bat_s1;
      sup_s1 <= supply_above;
      sup_s2 <= sup_s1;
    end
  end

  // rst stands for first power-up only; the supply monitor reset leaves these alone
  always @(posedge clk) begin
    if (rst) begin
      for (k = 0; k < 16; k = k + 1) begin
        alarm_mem[k] <= `ALARM_RESET;
      end
      protect_sel <= protect_reset[4:2];
      protect_keep <= protect_reset[1:0];
      analog_trim_code <= `ATRIM_RESET;
      digital_trim <= `DTRIM_RESET;
      serial_off_in_backup <= 1'b0;
      switchover_mode_sel <= SWITCHOVER_DEFAULT;
      supply_monitor_level <= `THR_RESET;
    end else if (ce && bus_on && scl_fall && bit_cnt == 4'h8 && state == ST_WRITE) begin
      if (addr <= `ADR_ALARM_LAST) begin
        if (addr[2:0] != `AL_YEAR) begin
          alarm_mem[addr[3:0]] <= shift;
        end
      end else begin
        case (addr)
          `ADR_PROTECT: begin
            protect_sel <= shift[`PROT_SEL_MSB:`PROT_SEL_LSB];
            protect_keep <= shift[`PROT_SEL_LSB-1:`PROT_KEEP_LSB];
          end
          `ADR_ATRIM: analog_trim_code <= shift[`ATRIM_MSB:0];
          `ADR_DTRIM: digital_trim <= shift[`DTRIM_SIGN:0];
          `ADR_POWER: begin
            serial_off_in_backup <= shift[`POWER_SERIAL_OFF];
            switchover_mode_sel <= shift[`POWER_SWITCHOVER];
            supply_monitor_level <= shift[`POWER_THR_MSB:0];
          end
          default: ;
        endcase
      end
    end
  end

  // serial slave
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'hFF;
      addr <= 16'h0000;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      status_clear <= 1'b0;
    end else if (ce) begin
      status_clear <= 1'b0;
      if (!bus_on) begin
        state <= ST_IDLE;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        state <= ST_DEV;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state <= ST_IDLE;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (state != ST_IDLE && scl_rise) begin
        if (bit_cnt < 4'h8) begin
          shift <= {shift[6:0], sda_s2};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (bit_cnt == 4'h9 && state == ST_READ && sda_s2) begin
          // master declined more data; wait for stop
          state <= ST_IDLE;
          bit_cnt <= 4'h0;
        end
      end else if (state != ST_IDLE && scl_fall) begin
        if (bit_cnt == 4'h8) begin
          bit_cnt <= 4'h9;
          case (state)
            ST_DEV: begin
              if (shift[7:1] == `CCR_DEV_ADDR) begin
                sda_oe <= 1'b1;
                state <= shift[0] ? ST_READ : ST_ADDR_HI;
              end else begin
                state <= ST_IDLE;
                bit_cnt <= 4'h0;
              end
            end
            ST_ADDR_HI: begin
              addr[15:8] <= shift;
              sda_oe <= 1'b1;
              state <= ST_ADDR_LO;
            end
            ST_ADDR_LO: begin
              addr[7:0] <= shift;
              sda_oe <= 1'b1;
              state <= ST_WRITE;
            end
            ST_WRITE: begin
              addr <= addr + 16'h0001;
              sda_oe <= 1'b1;
            end
            ST_READ: begin
              sda_oe <= 1'b0;
              addr <= addr + 16'h0001;
              status_clear <= (addr == `ADR_STATUS);
            end
            default: state <= ST_IDLE;
          endcase
        end else if (bit_cnt == 4'h9) begin
          bit_cnt <= 4'h0;
          if (state == ST_READ) begin
            tx <= rd_data;
            sda_oe <= ~rd_data[7];
          end else begin
            sda_oe <= 1'b0;
          end
        end else if (state == ST_READ && bit_cnt != 4'h0) begin
          tx <= {tx[6:0], 1'b1};
          sda_oe <= ~tx[6];
        end
      end
    end
  end

  // alarm flags, supply monitor and trim outputs
  always @(posedge clk) begin
    if (rst) begin
      alarm_flag_a <= 1'b0;
      alarm_flag_b <= 1'b0;
      reset_hold <= 1'b0;
      reset_out_n <= 1'b1;
      serial_active <= 1'b0;
      array_wr_grant <= 1'b0;
      trim_acc <= 21'h000000;
      second_length <= `OSC_COUNTS_PER_SEC;
      load_cap_code <= 6'h20;
    end else if (ce) begin
      // a match in the clearing cycle keeps its flag
      if (sec_tick && match_a) begin
        alarm_flag_a <= 1'b1;
      end else if (status_clear) begin
        alarm_flag_a <= 1'b0;
      end
      if (sec_tick && match_b) begin
        alarm_flag_b <= 1'b1;
      end else if (status_clear) begin
        alarm_flag_b <= 1'b0;
      end
      if (!bat_s2) begin
        reset_hold <= 1'b0;
      end else if (below_level) begin
        reset_hold <= 1'b1;
      end
      reset_out_n <= ~lvr_active;
      serial_active <= bus_on;
      array_wr_grant <= array_wr_req & ~in_protected;
      load_cap_code <= {~analog_trim_code[`ATRIM_MSB], analog_trim_code[`ATRIM_MSB-1:0]};
      if (sec_tick) begin
        // one extra or missing count whenever the ppm residue passes a whole count
        if (trim_sum >= `PPM_SCALE) begin
          trim_acc <= trim_sum - `PPM_SCALE;
          second_length <= digital_trim[`DTRIM_SIGN] ? `OSC_COUNTS_PER_SEC + 16'h0001 :
                           `OSC_COUNTS_PER_SEC - 16'h0001;
        end else begin
          trim_acc <= trim_sum;
          second_length <= `OSC_COUNTS_PER_SEC;
        end
      end
    end
  end
endmodule // rtc_alarm_ctrl

/* rtc_alarm_properties.sv */
`timescale 1ns/1ps
module rtc_alarm_checker #(
  parameter ARRAY_AW = 9
) (
  input wire clk,
  input wire rst,
  input wire sec_tick,
  input wire battery_mode,
  input wire array_wr_req,
  input wire array_wr_grant,
  input wire alarm_flag_a,
  input wire alarm_flag_b,
  input wire [5:0] analog_trim_code,
  input wire [5:0] load_cap_code,
  input wire [2:0] protect_sel,
  input wire [2:0] digital_trim,
  input wire [15:0] second_length,
  input wire reset_out_n,
  input wire serial_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // six cycles cover the two-flop synchroniser plus the registered output
  sequence batt_low_held;
    battery_mode [*6] ##0 !reset_out_n;
  endsequence
  sequence main_low_held;
    !battery_mode [*6] ##0 !reset_out_n [*2];
  endsequence
  grant_open_a: assert property (
    array_wr_req && protect_sel == 3'h0 |=> array_wr_grant) else $error("open write refused");
  full_lock_a: assert property (
    array_wr_req && protect_sel[1:0] == 2'h3 |=> !array_wr_grant) else $error("locked write granted");
  grant_cause_a: assert property (
    !array_wr_req |=> !array_wr_grant) else $error("grant without request");
  flag_a_tick_a: assert property (
    $rose(alarm_flag_a) |-> $past(sec_tick)) else $error("flag a set off tick");
  flag_b_tick_a: assert property (
    $rose(alarm_flag_b) |-> $past(sec_tick)) else $error("flag b set off tick");
  load_cap_a: assert property (
    load_cap_code == {~$past(analog_trim_code[5]), $past(analog_trim_code[4:0])})
    else $error("load cap code wrong");
  len_range_a: assert property (
    second_length == 16'h8000 || second_length == 16'h7FFF || second_length == 16'h8001)
    else $error("second length out of range");
  len_sign_a: assert property (
    $changed(second_length) && second_length != 16'h8000
    |-> second_length == (digital_trim[2] ? 16'h8001 : 16'h7FFF)) else $error("trim sign wrong");
  zero_mag_a: assert property (
    $changed(second_length) && digital_trim[1:0] == 2'h0 |-> second_length == 16'h8000)
    else $error("zero trim altered second");
  batt_hold_a: assert property (
    batt_low_held |=> !reset_out_n) else $error("reset released on battery");
  bus_dead_a: assert property (
    main_low_held |-> !serial_active) else $error("bus alive in reset");
endmodule // rtc_alarm_checker
bind rtc_alarm_ctrl rtc_alarm_checker #(.ARRAY_AW(ARRAY_AW)) u_checker (.*);

/* serial_host.sv */
`timescale 1ns/1ps
module serial_host (
  input wire clk,
  input wire sda,
  output reg scl,
  output reg sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task hold(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // long release before scl rises so a late ack release never looks like a stop
  task start;
    begin
      sda_low = 1'b0;
      hold(6);
      scl = 1'b1;
      hold(4);
      sda_low = 1'b1;
      hold(4);
      scl = 1'b0;
      hold(2);
    end
  endtask
  task stop;
    begin
      sda_low = 1'b1;
      hold(2);
      scl = 1'b1;
      hold(4);
      sda_low = 1'b0;
      hold(4);
    end
  endtask
  // sample late in the high phase: device data lags the synchronisers
  task bit_io(input b, output r);
    begin
      sda_low = !b;
      hold(2);
      scl = 1'b1;
      hold(3);
      r = sda;
      hold(1);
      scl = 1'b0;
      hold(2);
    end
  endtask
  task send(input [7:0] d, output ack);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
    end
  endtask
  task recv(input last, output [7:0] d);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, d[i]);
      bit_io(last, r);
    end
  endtask
endmodule // serial_host

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] time_sec = 8'h00, time_min = 8'h00, time_hour = 8'h00, time_date = 8'h00;
  reg [7:0] time_month = 8'h00, time_year = 8'h00, time_dow = 8'h00;
  reg sec_tick = 1'b0, battery_mode = 1'b0, array_wr_req = 1'b0;
  reg [4:0] supply_above = 5'h1F;
  reg [8:0] array_wr_addr = 9'h000;
  wire scl, host_low, sda_out, sda_oe, array_wr_grant, alarm_flag_a, alarm_flag_b;
  wire serial_off_in_backup, switchover_mode_sel, reset_out_n, serial_active;
  wire [2:0] protect_sel, digital_trim, supply_monitor_level;
  wire [5:0] analog_trim_code, load_cap_code;
  wire [15:0] second_length;
  wire sda = !(host_low | (sda_oe & !sda_out));
  integer fail_count = 0, checked = 0;
  localparam [89:0] EDGES = {9'h000, 9'h03F, 9'h040, 9'h07F, 9'h080, 9'h0FF, 9'h100,
    9'h17F, 9'h180, 9'h1FF};
  always #20 clk = ~clk;
  rtc_alarm_ctrl u_dut (.*, .ce(1'b1), .scl_in(scl), .sda_in(sda));
  serial_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      if (fail_count == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task wait_n(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task put(input [7:0] d);
    reg a;
    begin
      u_host.send(d, a);
      chk(a, 1);
    end
  endtask
  task addr(input [15:0] a);
    begin
      u_host.start;
      put(8'hDE);
      put(a[15:8]);
      put(a[7:0]);
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      addr(a);
      put(d);
      u_host.stop;
    end
  endtask
  task rd(input [15:0] a, output [7:0] d);
    begin
      addr(a);
      u_host.start;
      put(8'hDF);
      u_host.recv(1'b1, d);
      u_host.stop;
    end
  endtask
  task tick;
    begin
      sec_tick = 1'b1;
      wait_n(1);
      sec_tick = 1'b0;
      wait_n(2);
    end
  endtask
  task supply_chk(input [4:0] s, input [1:0] e);
    begin
      supply_above = s;
      wait_n(8);
      chk({reset_out_n, serial_active}, e);
    end
  endtask
  task test_defaults;
    begin
      chk({protect_sel, digital_trim, supply_monitor_level, switchover_mode_sel,
        serial_off_in_backup, reset_out_n, alarm_flag_a, alarm_flag_b}, 16'h0014);
      chk(second_length, 16'h8000);
      chk(load_cap_code, 16'h0020);
    end
  endtask
  task test_protect;
    integer c, i;
    reg [8:0] a;
    reg p;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        wr(16'h0010, {c[2:0], 5'h00});
        chk(protect_sel, c[2:0]);
        for (i = 0; i < 10; i = i + 1) begin
          a = EDGES[i*9 +: 9];
          case (c)
            1: p = a >= 9'h180;
            2: p = a >= 9'h100;
            3, 7: p = 1'b1;
            4: p = a <= 9'h03F;
            5: p = a <= 9'h07F;
            6: p = a <= 9'h0FF;
            default: p = 1'b0;
          endcase
          array_wr_addr = a;
          array_wr_req = 1'b1;
          wait_n(1);
          array_wr_req = 1'b0;
          chk(array_wr_grant, !p);
          wait_n(1);
        end
      end
    end
  endtask
  task test_trim;
    begin
      wr(16'h0012, 8'h3F);
      chk(load_cap_code, 16'h001F);
      wr(16'h0012, 8'h20);
      chk(load_cap_code, 16'h0000);
      wr(16'h0013, 8'h03);
      chk(digital_trim, 16'h0003);
      tick;
      chk(second_length, 16'h8000);
      tick;
      chk(second_length, 16'h7FFF);
      wr(16'h0013, 8'h07);
      tick;
      chk(second_length, 16'h8001);
      wr(16'h0020, 8'hFF);
      chk({digital_trim, analog_trim_code}, 16'h01E0);
    end
  endtask
  task test_alarm;
    reg [7:0] d;
    begin
      time_sec = 8'h15;
      time_min = 8'h30;
      time_hour = 8'h12;
      time_year = 8'h99;
      wr(16'h0000, 8'h95);
      wr(16'h0005, 8'h80);
      wr(16'h0009, 8'hB0);
      wr(16'h000A, 8'h92);
      wait_n(4);
      chk({alarm_flag_b, alarm_flag_a}, 16'h0000);
      tick;
      chk({alarm_flag_b, alarm_flag_a}, 16'h0003);
      rd(16'h003F, d);
      chk(d, 16'h0060);
      chk({alarm_flag_b, alarm_flag_a}, 16'h0000);
      time_min = 8'h31;
      tick;
      chk({alarm_flag_b, alarm_flag_a}, 16'h0001);
      rd(16'h003F, d);
      chk(d, 16'h0020);
    end
  endtask
  task test_power;
    begin
      wr(16'h0014, 8'h02);
      chk({serial_off_in_backup, switchover_mode_sel, supply_monitor_level}, 16'h0002);
      supply_chk(5'h1C, 2'b11);
      supply_chk(5'h18, 2'b00);
      supply_chk(5'h1F, 2'b11);
      chk(supply_monitor_level, 16'h0002);
      battery_mode = 1'b1;
      supply_chk(5'h18, 2'b00);
      supply_chk(5'h1F, 2'b00);
      battery_mode = 1'b0;
      supply_chk(5'h1F, 2'b11);
      wr(16'h0014, 8'hC5);
      chk({serial_off_in_backup, switchover_mode_sel, supply_monitor_level}, 16'h001D);
      battery_mode = 1'b1;
      supply_chk(5'h1F, 2'b10);
      battery_mode = 1'b0;
      supply_chk(5'h1F, 2'b11);
      supply_chk(5'h1E, 2'b00);
      supply_chk(5'h1F, 2'b11);
    end
  endtask
  initial begin
    wait_n(2);
    rst = 1'b0;
    wait_n(5);
    test_defaults;
    test_protect;
    test_trim;
    test_alarm;
    test_power;
    final_report;
  end
  initial begin
    #3000000;
    fail_count = fail_count + 1;
    final_report;
  end
endmodule // testbench
